// ---- hdl/status_pkg.sv ----
// Purpose: Shared constants for the servo status output block
// Assumes: 10 MHz hclk, AHB-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package status_pkg;
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned PWRON_MS      = 1000;
    localparam int unsigned PWRON_CYCLES  = CLK_HZ / 1000 * PWRON_MS;
    localparam int unsigned DELAY_MS_DIV  = CLK_HZ / 1000;
    localparam int          SYNC_STAGES   = 3;
    localparam int          DROOP_W       = 24;
    localparam int          DELAY_W       = 16;
    localparam int          ASSIGN_W      = 4;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RANGE  = 8'h04;
    localparam logic [7:0] OFS_DELAY  = 8'h08;
    localparam logic [7:0] OFS_ASSIGN = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQST  = 8'h14;
    localparam logic [7:0] OFS_IRQMSK = 8'h18;

    localparam logic [DROOP_W-1:0] RANGE_RST  = 24'h000064;
    localparam logic [DELAY_W-1:0] DELAY_RST  = 16'h0000;
    localparam logic [ASSIGN_W-1:0] ASSIGN_RST = 4'h0;

    // Status and interrupt bit positions
    localparam int BIT_BRAKE = 0;
    localparam int BIT_INPOS = 1;
    localparam int BIT_READY = 2;
    localparam int BIT_DBIL  = 3;
    localparam int BIT_TRBL  = 4;
    localparam int NSTAT     = 5;

    // Assign register: bit 0 ready pin enable, bit 1 dynamic brake pin enable
    localparam int ASN_READY = 0;
    localparam int ASN_DBIL  = 1;

    typedef enum logic [1:0] {
        LOOP_POSITION,
        LOOP_SPEED,
        LOOP_TORQUE
    } loop_mode_type;
endpackage : status_pkg

// ---- hdl/pin_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to hclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output logic      level
);
    logic [status_pkg::SYNC_STAGES-1:0] stage_q;
    logic [status_pkg::SYNC_STAGES-1:0] stage_d;
    logic                               level_q;
    logic                               level_d;

    always_comb begin
        stage_d = {stage_q[status_pkg::SYNC_STAGES-2:0], pin};
        level_d = level_q;
        // Change only once stages two and three agree
        if (stage_q[1] == stage_q[2]) begin
            level_d = stage_q[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_q <= '0;
            level_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule : pin_sync

// ---- hdl/servo_status_outputs.sv ----
// Purpose: Status outputs of a servo driver, with AHB-Lite registers
// Assumes: 10 MHz hclk; pin-level inputs from the drive core
// Notes:   Overview of operation and tags below
//
// Overview of operation
// - Brake interlock off while servo is off or an alarm is active.
// - Brake interlock turns on after the programmed brake delay.
// - In-position on while droop magnitude is within the range.
// - In-position range comes from a writable register.
// - Slow rotation inside a wide range may show in-position; not blocked.
// - In-position asserts when servo-on becomes active.
// - In-position is held off in speed loop mode.
// - Ready on only when servo on and driver prepared.
// - Dynamic brake interlock drops the cycle after the synchronised brake input rises.
// - Alarm equals trouble output inactive: power-off or base shutoff.
// - Trouble output asserts about one second after power-on.
`timescale 1ns/1ps
module servo_status_outputs #(
    parameter int unsigned PWRON_CYCLES = status_pkg::PWRON_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        servo_on,
    input  wire logic        alarm,
    input  wire logic        drive_prepared,
    input  wire logic        dyn_brake_active,
    input  wire logic [1:0]  loop_mode,
    input  wire logic [23:0] droop_count,
    output logic             brake_interlock_out,
    output logic             in_position_out,
    output logic             ready_out,
    output logic             dyn_brake_interlock_out,
    output logic             trouble_out,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic servo_on_s;
    logic alarm_s;
    logic prepared_s;
    logic dbrake_s;

    pin_sync u_sync_son (.hclk(hclk), .hresetn(hresetn), .pin(servo_on),
                         .level(servo_on_s));
    pin_sync u_sync_alm (.hclk(hclk), .hresetn(hresetn), .pin(alarm),
                         .level(alarm_s));
    pin_sync u_sync_prp (.hclk(hclk), .hresetn(hresetn),
                         .pin(drive_prepared), .level(prepared_s));
    pin_sync u_sync_dbk (.hclk(hclk), .hresetn(hresetn),
                         .pin(dyn_brake_active), .level(dbrake_s));

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    logic                                   wr_pend_q;
    logic                                   wr_pend_d;
    logic                                   rd_pend_q;
    logic                                   rd_pend_d;
    logic [7:0]                             addr_q;
    logic [7:0]                             addr_d;
    logic [31:0]                            rdata_q;
    logic [31:0]                            rdata_d;
    logic                                   ctrl_irq_clr;
    logic [status_pkg::DROOP_W-1:0]         range_q;
    logic [status_pkg::DROOP_W-1:0]         range_d;
    logic [status_pkg::DELAY_W-1:0]         delay_q;
    logic [status_pkg::DELAY_W-1:0]         delay_d;
    logic [status_pkg::ASSIGN_W-1:0]        assign_q;
    logic [status_pkg::ASSIGN_W-1:0]        assign_d;
    logic [status_pkg::NSTAT-1:0]           mask_q;
    logic [status_pkg::NSTAT-1:0]           mask_d;
    logic [status_pkg::NSTAT-1:0]           stat_vec;

    function automatic logic [31:0] read_mux(
        input logic [7:0]                      a,
        input logic [status_pkg::DROOP_W-1:0]  rng,
        input logic [status_pkg::DELAY_W-1:0]  dly,
        input logic [status_pkg::ASSIGN_W-1:0] asn,
        input logic [status_pkg::NSTAT-1:0]    st,
        input logic [status_pkg::NSTAT-1:0]    ist,
        input logic [status_pkg::NSTAT-1:0]    msk
    );
        logic [31:0] r;
        r = 32'h00000000;
        unique case (a)
            status_pkg::OFS_RANGE:  r[status_pkg::DROOP_W-1:0] = rng;
            status_pkg::OFS_DELAY:  r[status_pkg::DELAY_W-1:0] = dly;
            status_pkg::OFS_ASSIGN: r[status_pkg::ASSIGN_W-1:0] = asn;
            status_pkg::OFS_STATUS: r[status_pkg::NSTAT-1:0] = st;
            status_pkg::OFS_IRQST:  r[status_pkg::NSTAT-1:0] = ist;
            status_pkg::OFS_IRQMSK: r[status_pkg::NSTAT-1:0] = msk;
            default:                r = 32'h00000000;
        endcase
        return r;
    endfunction : read_mux

    logic [status_pkg::NSTAT-1:0] ist_q;
    logic [status_pkg::NSTAT-1:0] ist_d;
    logic [status_pkg::NSTAT-1:0] stat_prev_q;

    always_comb begin
        logic take;
        take      = hsel && hready && htrans[1];
        wr_pend_d = take && hwrite;
        rd_pend_d = take && !hwrite;
        addr_d    = take ? haddr[7:0] : addr_q;
        range_d   = range_q;
        delay_d   = delay_q;
        assign_d  = assign_q;
        mask_d    = mask_q;
        rdata_d   = rdata_q;
        if (wr_pend_q) begin
            unique case (addr_q)
                status_pkg::OFS_RANGE:
                    range_d = hwdata[status_pkg::DROOP_W-1:0];
                status_pkg::OFS_DELAY:
                    delay_d = hwdata[status_pkg::DELAY_W-1:0];
                status_pkg::OFS_ASSIGN:
                    assign_d = hwdata[status_pkg::ASSIGN_W-1:0];
                status_pkg::OFS_IRQMSK:
                    mask_d = hwdata[status_pkg::NSTAT-1:0];
                default: ;
            endcase
        end
        if (rd_pend_d) begin
            rdata_d = read_mux(haddr[7:0], range_q, delay_q, assign_q,
                               stat_vec, ist_q, mask_q);
        end
    end

    assign ctrl_irq_clr = rd_pend_q && (addr_q == status_pkg::OFS_IRQST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            rdata_q   <= 32'h00000000;
            range_q   <= status_pkg::RANGE_RST;
            delay_q   <= status_pkg::DELAY_RST;
            assign_q  <= status_pkg::ASSIGN_RST;
            mask_q    <= '0;
        end else begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q    <= addr_d;
            rdata_q   <= rdata_d;
            range_q   <= range_d;
            delay_q   <= delay_d;
            assign_q  <= assign_d;
            mask_q    <= mask_d;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Status generation
    logic                          trouble_q, trouble_d;
    logic [23:0]                   pwr_cnt_q, pwr_cnt_d;
    logic [status_pkg::DELAY_W-1:0] ms_cnt_q, ms_cnt_d;
    logic [15:0]                   tick_q, tick_d;
    logic                          brake_q, brake_d;
    logic                          inpos_q, inpos_d;
    logic                          ready_q, ready_d;
    logic                          dbil_q, dbil_d;
    logic                          son_prev_q;
    logic                          fault;
    logic [status_pkg::DROOP_W-1:0] droop_mag;

    assign fault     = alarm_s || !trouble_q;
    assign droop_mag = droop_count[status_pkg::DROOP_W-1]
                       ? (~droop_count + 24'h000001) : droop_count;

    always_comb begin
        trouble_d = trouble_q;
        pwr_cnt_d = pwr_cnt_q;
        if (alarm_s) begin
            trouble_d = 1'b0;
        end else if (pwr_cnt_q == 24'(PWRON_CYCLES - 1)) begin
            trouble_d = 1'b1;
        end else begin
            pwr_cnt_d = pwr_cnt_q + 24'h000001;
        end
        tick_d   = tick_q;
        ms_cnt_d = ms_cnt_q;
        brake_d  = brake_q;
        if (!servo_on_s || fault) begin
            brake_d  = 1'b0;
            tick_d   = 16'h0000;
            ms_cnt_d = '0;
        end else if (!brake_q) begin
            if (ms_cnt_q >= delay_q) begin
                brake_d = 1'b1;
            end else if (tick_q == 16'(status_pkg::DELAY_MS_DIV - 1)) begin
                tick_d   = 16'h0000;
                ms_cnt_d = ms_cnt_q + 16'h0001;
            end else begin
                tick_d = tick_q + 16'h0001;
            end
        end
        // in-position; slow motion is not suppressed
        inpos_d = 1'b0;
        if (loop_mode != status_pkg::LOOP_SPEED) begin
            inpos_d = (droop_mag <= range_q) ||
                      (servo_on_s && !son_prev_q);
        end
        ready_d = assign_q[status_pkg::ASN_READY] && servo_on_s &&
                  prepared_s && !fault;
        dbil_d = assign_q[status_pkg::ASN_DBIL] && !dbrake_s;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trouble_q  <= 1'b0;
            pwr_cnt_q  <= 24'h000000;
            tick_q     <= 16'h0000;
            ms_cnt_q   <= '0;
            brake_q    <= 1'b0;
            inpos_q    <= 1'b0;
            ready_q    <= 1'b0;
            dbil_q     <= 1'b0;
            son_prev_q <= 1'b0;
        end else begin
            trouble_q  <= trouble_d;
            pwr_cnt_q  <= pwr_cnt_d;
            tick_q     <= tick_d;
            ms_cnt_q   <= ms_cnt_d;
            brake_q    <= brake_d;
            inpos_q    <= inpos_d;
            ready_q    <= ready_d;
            dbil_q     <= dbil_d;
            son_prev_q <= servo_on_s;
        end
    end

    assign brake_interlock_out     = brake_q;
    assign in_position_out         = inpos_q;
    assign ready_out               = ready_q;
    assign dyn_brake_interlock_out = dbil_q;
    assign trouble_out             = trouble_q;
    assign stat_vec = {trouble_q, dbil_q, ready_q, inpos_q, brake_q};

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky on any status change; read clears, set wins
    logic irq_q, irq_d;

    always_comb begin
        ist_d = ist_q;
        // Clear only reported bits; an event at the address edge survives
        if (ctrl_irq_clr) begin
            ist_d = ist_q & ~rdata_q[status_pkg::NSTAT-1:0];
        end
        ist_d = ist_d | (stat_vec ^ stat_prev_q);
        irq_d = |(ist_d & mask_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ist_q       <= '0;
            stat_prev_q <= '0;
            irq_q       <= 1'b0;
        end else begin
            ist_q       <= ist_d;
            stat_prev_q <= stat_vec;
            irq_q       <= irq_d;
        end
    end

    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    brake_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!servo_on_s || fault) |=> !brake_interlock_out)
        else $error("brake interlock on while off or faulted");
    speed_inpos_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (loop_mode == status_pkg::LOOP_SPEED) |=> !in_position_out)
        else $error("in-position asserted in speed loop");
    inpos_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (loop_mode != status_pkg::LOOP_SPEED && droop_mag <= range_q)
        |=> in_position_out)
        else $error("in-position missing inside range");
    ready_cond_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ready_out |-> $past(servo_on_s && prepared_s))
        else $error("ready without servo on and prepared");
    dbil_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(dbrake_s) |=> !dyn_brake_interlock_out)
        else $error("dynamic brake interlock not dropped");
    son_inpos_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(servo_on_s) && loop_mode != status_pkg::LOOP_SPEED)
        |=> in_position_out)
        else $error("in-position missing at servo on");
    alarm_trbl_a: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm_s |=> !trouble_out)
        else $error("trouble output on during alarm");
    reset_out_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> !brake_interlock_out && !ready_out)
        else $error("outputs not low after reset");
    brake_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(brake_interlock_out) |-> ms_cnt_q >= delay_q)
        else $error("brake interlock before delay");
endmodule : servo_status_outputs

// ---- sim/host_model.sv ----
// Purpose: Host controller view of the driver's status pins
// Assumes: Pins are sampled once per hclk
// Notes:   Unassigned pins are ignored, as a real controller would
`timescale 1ns/1ps
module host_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] asn,
    input  wire logic       ready_pin,
    input  wire logic       dbil_pin,
    output logic            ready_seen_q,
    output logic            dbil_seen_q
);
    // External dynamic brake is fitted, so the interlock pin matters
    localparam logic EXT_DB_FITTED = 1'b1;
    logic ready_seen_d;
    logic dbil_seen_d;
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ready_seen_d = asn[0] & ready_pin;
        dbil_seen_d  = asn[1] & EXT_DB_FITTED & dbil_pin;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_seen_q <= 1'b0;
            dbil_seen_q  <= 1'b0;
        end else begin
            ready_seen_q <= ready_seen_d;
            dbil_seen_q  <= dbil_seen_d;
        end
    end
endmodule : host_model

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the servo status outputs
// Assumes: hreadyout is fed back as hready; waits are unbounded per call
// Notes:   Power-on delay is shortened so trouble rises within the run
`timescale 1ns/1ps
module tb_top;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, loop_mode, asn;
    logic [2:0]  hsize;
    logic        servo_on, alarm, drive_prepared, dyn_brake_active;
    logic [23:0] droop_count;
    logic        brake, inpos, ready, dbil, trouble, h_ready, h_dbil;
    int          n_errors, checks, cycles, seen;
    logic [23:0] dv [5] = '{24'h000000, 24'h000064, 24'h000065,
                            24'hFFFF9C, 24'hFFFF9B};
    logic [4:0]  dx = 5'h0B;
    // Short power-on delay so trouble, brake and ready can rise in the run
    localparam int unsigned PWRON_SHORT = 200;
    ////////////////////////////////////////////////////////////////////////
    servo_status_outputs #(.PWRON_CYCLES(PWRON_SHORT)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .servo_on(servo_on), .alarm(alarm),
        .drive_prepared(drive_prepared),
        .dyn_brake_active(dyn_brake_active), .loop_mode(loop_mode),
        .droop_count(droop_count), .brake_interlock_out(brake),
        .in_position_out(inpos), .ready_out(ready),
        .dyn_brake_interlock_out(dbil), .trouble_out(trouble), .irq(irq)
    );
    host_model i_host (
        .hclk(hclk), .hresetn(hresetn), .asn(asn), .ready_pin(ready),
        .dbil_pin(dbil), .ready_seen_q(h_ready), .dbil_seen_q(h_dbil)
    );
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Ceiling well above the roughly 10400 cycles the tests need
    always @(posedge hclk) begin
        cycles++;
        if (cycles > 40000) begin
            n_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    // Single word transfer; holds each phase until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask : rchk
    function automatic logic [31:0] outs();
        return {26'h0000000, brake, inpos, ready, dbil, trouble, irq};
    endfunction : outs
    task automatic summarize;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        servo_on = 1'b0;
        alarm = 1'b0;
        drive_prepared = 1'b0;
        dyn_brake_active = 1'b0;
        loop_mode = status_pkg::LOOP_POSITION;
        droop_count = 24'h000000;
        asn = 2'h0;
        n_errors = 0;
        checks = 0;
        cycles = 0;
        cyc(5);
        check(outs(), 32'h00000000);
        hresetn <= 1'b1;
        cyc(1);
        rchk(status_pkg::OFS_RANGE, 32'h00000064);
        rchk(status_pkg::OFS_DELAY, 32'h00000000);
        rchk(status_pkg::OFS_ASSIGN, 32'h00000000);
        bus(1'b1, 8'h1C, 32'hFFFFFFFF);
        rchk(8'h1C, 32'h00000000);
        rchk(status_pkg::OFS_CTRL, 32'h00000000);
        check({31'h00000000, hresp}, 32'h00000000);
        bus(1'b1, status_pkg::OFS_DELAY, 32'hFFFFFFFF);
        rchk(status_pkg::OFS_DELAY, 32'h0000FFFF);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            droop_count <= dv[i];
            cyc(4);
            check({31'h00000000, inpos}, {31'h00000000, dx[i]});
        end
        bus(1'b1, status_pkg::OFS_RANGE, 32'h000000C8);
        droop_count <= 24'h000096;
        cyc(4);
        check({31'h00000000, inpos}, 32'h00000001);
        rchk(status_pkg::OFS_STATUS, 32'h00000002);
        loop_mode <= status_pkg::LOOP_SPEED;
        cyc(4);
        check({31'h00000000, inpos}, 32'h00000000);
        loop_mode <= status_pkg::LOOP_POSITION;
        $display("test in-position done");
        droop_count <= 24'h001000;
        asn <= 2'h3;
        bus(1'b1, status_pkg::OFS_ASSIGN, 32'h00000003);
        drive_prepared <= 1'b1;
        cyc(8);
        bus(1'b0, status_pkg::OFS_IRQST, 32'h00000000);
        servo_on <= 1'b1;
        seen = 0;
        repeat (10) begin
            @(posedge hclk);
            if (inpos === 1'b1) seen++;
            check({30'h00000000, brake, ready}, 32'h00000000);
        end
        check({31'h00000000, seen != 0}, 32'h00000001);
        check({31'h00000000, h_ready}, 32'h00000000);
        bus(1'b0, status_pkg::OFS_IRQST, 32'h00000000);
        check(rd & 32'h00000002, 32'h00000002);
        rchk(status_pkg::OFS_IRQST, 32'h00000000);
        check({31'h00000000, irq}, 32'h00000000);
        bus(1'b1, status_pkg::OFS_IRQMSK, 32'h00000002);
        droop_count <= 24'h000000;
        cyc(4);
        check({31'h00000000, irq}, 32'h00000001);
        bus(1'b0, status_pkg::OFS_IRQST, 32'h00000000);
        cyc(2);
        check({31'h00000000, irq}, 32'h00000000);
        $display("test servo-on and interrupt done");
        dyn_brake_active <= 1'b1;
        cyc(8);
        check({30'h00000000, dbil, h_dbil}, 32'h00000000);
        asn <= 2'h0;
        bus(1'b1, status_pkg::OFS_ASSIGN, 32'h00000000);
        dyn_brake_active <= 1'b0;
        cyc(6);
        check({30'h00000000, dbil, ready}, 32'h00000000);
        $display("test interlock done");
        cyc(PWRON_SHORT);
        check({31'h00000000, trouble}, 32'h00000001);
        servo_on <= 1'b0;
        asn <= 2'h1;
        bus(1'b1, status_pkg::OFS_ASSIGN, 32'h00000001);
        bus(1'b1, status_pkg::OFS_DELAY, 32'h00000001);
        servo_on <= 1'b1;
        // One millisecond of delay is about 10000 cycles after sync
        cyc(9950);
        check({30'h00000000, brake, h_ready}, 32'h00000001);
        cyc(100);
        check({30'h00000000, brake, ready}, 32'h00000003);
        alarm <= 1'b1;
        cyc(8);
        check({29'h00000000, brake, ready, trouble}, 32'h00000000);
        $display("test brake and ready done");
        hresetn <= 1'b0;
        cyc(2);
        check(outs(), 32'h00000000);
        hresetn <= 1'b1;
        cyc(1);
        rchk(status_pkg::OFS_RANGE, 32'h00000064);
        $display("test second reset done");
        summarize();
    end
endmodule : tb_top
